// ---- core/hsm_params.svh ----
// Functional notes
// - Hilbert FIR: 19 taps, odd antisymmetric integers.
// - Hilbert path oscillator leads by quarter cycle.
// - Hilbert enable adds filter output in dual mode only (sideband bit 1 subtracts), else bypass.
// - Main path delayed nine cycles for alignment.
// - Sideband bit: 0 rejects upper, 1 lower.
// - Enabled master drives reference clock pin.
// - Slave takes reference clock pin as input.
// - Modulator master: 16-cycle square, rise at zero.
// - 16-state counter makes all sync clocks.
// - Modulator mode slave aligns state zero.
// - Data-clock master: reference at channel rate.
// - New phase offset applies at state zero.
// - Modulator mode slaves lock phase automatically.
// - Slave latches input with local data clock.
// - Data-clock offset advances eight, delays seven.
// - Coefficients decoded from state every cycle.
// - Phase offset rotates coefficient sequence start.
// - Channel bit picks real or imaginary result in dual mode, else I or Q input times cosine.
`ifndef HSM_PARAMS_SVH
`define HSM_PARAMS_SVH
`define HSM_REG_CTRL 4'h0
`define HSM_REG_PHASE 4'h4
`define HSM_REG_STATUS 4'h8
`define HSM_B_DUAL 0
`define HSM_B_CHAN 1
`define HSM_B_HILB 2
`define HSM_B_SIDE 3
`define HSM_B_SYNC 4
`define HSM_B_MAST 5
`define HSM_B_DCKM 6
`define HSM_F_MOD 8:7
`define HSM_F_INTP 10:9
`define HSM_F_MADJ 3:0
`define HSM_F_DADJ 7:4
`define HSM_CTRL_RST 11'h000
`define HSM_PHASE_RST 8'h00
`define HSM_COEF_ONE 17'sh04000
`define HSM_COEF_R2 17'sh02d41
`define HSM_COEF_SH 14
`define HSM_HILB_SH 9
`define HSM_HILB_CENTER 9
`define HSM_SYNC_LAT 4'h3
`define HSM_STATE_ZERO 4'h0
`define HSM_HALF_STATE 4'h8
`define HSM_QTR 3'h2
`endif

// ---- core/hsm_pkg.sv ----
package hsm_pkg;
    typedef enum logic [1:0] {HSM_MOD_NONE, HSM_MOD_FS2, HSM_MOD_FS4, HSM_MOD_FS8} hsm_mod_t;
    typedef enum {HSM_SYNC_OFF, HSM_SYNC_MASTER, HSM_SYNC_WAIT, HSM_SYNC_LOCKED} hsm_sync_t;
endpackage : hsm_pkg

// ---- core/hsm_top.sv ----
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsm_params.svh"
module hsm_top
    import hsm_pkg::*;
#(
    parameter int DW = 16
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register bus.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interpolated channel samples.
    input wire logic signed [DW-1:0] i_in,
    input wire logic signed [DW-1:0] q_in,
    // Converter side.
    output logic signed [DW-1:0] dac_out,
    output logic data_latch_clk,
    // Reference clock pin.
    input wire logic sync_reference_clock_pin_i,
    output logic sync_reference_clock_pin_o,
    output logic sync_reference_clock_pin_oe
);

    localparam int AW = DW + 2;

    function automatic logic signed [16:0] cos8(input logic [2:0] ph);
        logic signed [16:0] c;
        c = 17'sh00000;
        case (ph)
            3'h0: c = `HSM_COEF_ONE;
            3'h1: c = `HSM_COEF_R2;
            3'h3: c = -`HSM_COEF_R2;
            3'h4: c = -`HSM_COEF_ONE;
            3'h5: c = -`HSM_COEF_R2;
            3'h7: c = `HSM_COEF_R2;
            default: c = 17'sh00000;
        endcase
        return c;
    endfunction : cos8

    function automatic logic [2:0] phase_of(input logic [3:0] cnt, input hsm_mod_t m);
        logic [2:0] p;
        p = 3'h0;
        case (m)
            HSM_MOD_FS2: p = {cnt[0], 2'b00};
            HSM_MOD_FS4: p = {cnt[1:0], 1'b0};
            HSM_MOD_FS8: p = cnt[2:0];
            default: p = 3'h0;
        endcase
        return p;
    endfunction : phase_of

    function automatic logic signed [AW-1:0] mix(input logic signed [DW-1:0] a,
                                                 input logic signed [16:0] c);
        logic signed [DW+16:0] p;
        p = a * c;
        return AW'(p >>> `HSM_COEF_SH);
    endfunction : mix

    function automatic logic signed [DW-1:0] sat(input logic signed [AW+1:0] v);
        logic signed [AW+1:0] hi;
        logic signed [AW+1:0] lo;
        hi = (AW+2)'({1'b0, {(DW-1){1'b1}}});
        lo = -hi - (AW+2)'(1);
        if (v > hi)
            return hi[DW-1:0];
        else if (v < lo)
            return lo[DW-1:0];
        return v[DW-1:0];
    endfunction : sat

    logic [10:0] ctrl_r;
    logic [7:0] phase_r;
    logic ack_r;
    logic [3:0] state_r;
    logic [3:0] madj_act_r;
    logic ref_s1_r;
    logic ref_s2_r;
    logic ref_s3_r;
    logic dclk_d_r;
    hsm_sync_t sync_r;
    hsm_sync_t sync_nxt;
    logic signed [DW-1:0] i_lat_r;
    logic signed [DW-1:0] q_lat_r;
    logic signed [AW-1:0] hil_x_r [0:2*`HSM_HILB_CENTER-1];
    logic signed [AW-1:0] main_d_r [0:`HSM_HILB_CENTER-1];

    hsm_mod_t mod_mode;
    logic dual;
    logic hil_on;
    logic is_master;
    logic ref_rise;
    logic [3:0] div_mask;
    logic [3:0] dcnt;
    logic dclk;
    logic [3:0] mcnt;
    logic [2:0] ph;
    logic signed [16:0] c_m;
    logic signed [16:0] s_m;
    logic signed [16:0] c_h;
    logic signed [16:0] s_h;
    logic signed [AW-1:0] re_m;
    logic signed [AW-1:0] im_m;
    logic signed [AW-1:0] main_v;
    logic signed [AW-1:0] hil_v;
    logic signed [AW+15:0] fir_acc;
    logic signed [AW+1:0] sum_v;
    logic req;

    assign mod_mode = hsm_mod_t'(ctrl_r[`HSM_F_MOD]);
    assign dual = ctrl_r[`HSM_B_DUAL];
    assign hil_on = dual & ctrl_r[`HSM_B_HILB];
    assign is_master = ctrl_r[`HSM_B_SYNC] & ctrl_r[`HSM_B_MAST];
    assign div_mask = 4'((5'h2 << ctrl_r[`HSM_F_INTP]) - 5'h1);

    // Register bus: one wait cycle, then the answer.
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= `HSM_CTRL_RST;
            phase_r <= `HSM_PHASE_RST;
        end
        else if (avs_write && ack_r)
        begin
            if (avs_address == `HSM_REG_CTRL)
            begin
                if (avs_byteenable[0])
                    ctrl_r[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    ctrl_r[10:8] <= avs_writedata[10:8];
            end
            else if (avs_address == `HSM_REG_PHASE && avs_byteenable[0])
                phase_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !ack_r)
        begin
            case (avs_address)
                `HSM_REG_CTRL: avs_readdata <= {21'h0, ctrl_r};
                `HSM_REG_PHASE: avs_readdata <= {24'h0, phase_r};
                `HSM_REG_STATUS: avs_readdata <= {22'h0,
                    sync_r == HSM_SYNC_LOCKED, madj_act_r, 1'b0, state_r};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // Reference pin synchroniser.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end
        else
        begin
            ref_s1_r <= sync_reference_clock_pin_i;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
        end
    end

    assign ref_rise = ref_s2_r & ~ref_s3_r & ctrl_r[`HSM_B_SYNC] & ~ctrl_r[`HSM_B_MAST];

    always_comb
    begin
        sync_nxt = sync_r;
        case (sync_r)
            HSM_SYNC_OFF:
                if (is_master)
                    sync_nxt = HSM_SYNC_MASTER;
                else if (ctrl_r[`HSM_B_SYNC])
                    sync_nxt = HSM_SYNC_WAIT;
            HSM_SYNC_MASTER:
                if (!is_master)
                    sync_nxt = HSM_SYNC_OFF;
            HSM_SYNC_WAIT:
                if (!ctrl_r[`HSM_B_SYNC] || is_master)
                    sync_nxt = HSM_SYNC_OFF;
                else if (ref_rise)
                    sync_nxt = HSM_SYNC_LOCKED;
            HSM_SYNC_LOCKED:
                if (!ctrl_r[`HSM_B_SYNC] || is_master)
                    sync_nxt = HSM_SYNC_OFF;
            default: sync_nxt = HSM_SYNC_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sync_r <= HSM_SYNC_OFF;
        else
            sync_r <= sync_nxt;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= `HSM_STATE_ZERO;
        else if (ref_rise && !ctrl_r[`HSM_B_DCKM])
            state_r <= `HSM_SYNC_LAT;
        else if (ref_rise)
            state_r <= (state_r & ~div_mask) | (`HSM_SYNC_LAT & div_mask);
        else
            state_r <= state_r + 4'h1;
    end

    assign dcnt = state_r - phase_r[`HSM_F_DADJ];
    assign dclk = (dcnt & div_mask) <= (div_mask >> 1);
    assign data_latch_clk = dclk_d_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dclk_d_r <= 1'b0;
        else
            dclk_d_r <= dclk;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            i_lat_r <= '0;
            q_lat_r <= '0;
        end
        else if (dclk && !dclk_d_r)
        begin
            i_lat_r <= i_in;
            q_lat_r <= q_in;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_reference_clock_pin_o <= 1'b0;
            sync_reference_clock_pin_oe <= 1'b0;
        end
        else
        begin
            sync_reference_clock_pin_oe <= is_master;
            if (ctrl_r[`HSM_B_DCKM])
                sync_reference_clock_pin_o <= dclk;
            else
                sync_reference_clock_pin_o <= 4'(state_r + 4'h1) < `HSM_HALF_STATE;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            madj_act_r <= 4'h0;
        else if (state_r == `HSM_STATE_ZERO)
            madj_act_r <= phase_r[`HSM_F_MADJ];
    end

    assign mcnt = state_r + madj_act_r;
    assign ph = phase_of(mcnt, mod_mode);
    assign c_m = cos8(ph);
    assign s_m = cos8(ph - `HSM_QTR);
    assign c_h = cos8(ph + `HSM_QTR);
    assign s_h = cos8(ph);

    always_comb
    begin
        re_m = mix(i_lat_r, c_m) - mix(q_lat_r, s_m);
        im_m = mix(i_lat_r, s_m) + mix(q_lat_r, c_m);
        hil_v = ctrl_r[`HSM_B_CHAN] ? mix(i_lat_r, s_h) + mix(q_lat_r, c_h)
                                    : mix(i_lat_r, c_h) - mix(q_lat_r, s_h);
        if (!dual)
            main_v = ctrl_r[`HSM_B_CHAN] ? mix(q_lat_r, c_m) : mix(i_lat_r, c_m);
        else
            main_v = ctrl_r[`HSM_B_CHAN] ? im_m : re_m;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int k = 0; k < `HSM_HILB_CENTER; k++)
                main_d_r[k] <= '0;
            for (int k = 0; k < 2*`HSM_HILB_CENTER; k++)
                hil_x_r[k] <= '0;
        end
        else
        begin
            main_d_r[0] <= main_v;
            for (int k = 1; k < `HSM_HILB_CENTER; k++)
                main_d_r[k] <= main_d_r[k-1];
            hil_x_r[0] <= hil_v;
            for (int k = 1; k < 2*`HSM_HILB_CENTER; k++)
                hil_x_r[k] <= hil_x_r[k-1];
        end
    end

    always_comb
    begin
        fir_acc = (AW+16)'(hil_x_r[17] - hil_v) * 6
                + (AW+16)'(hil_x_r[15] - hil_x_r[1]) * 17
                + (AW+16)'(hil_x_r[13] - hil_x_r[3]) * 40
                + (AW+16)'(hil_x_r[11] - hil_x_r[5]) * 91
                + (AW+16)'(hil_x_r[9] - hil_x_r[7]) * 318;
    end

    always_comb
    begin
        sum_v = (AW+2)'(main_d_r[`HSM_HILB_CENTER-1]);
        if (hil_on && !ctrl_r[`HSM_B_SIDE])
            sum_v = sum_v + (AW+2)'(fir_acc >>> `HSM_HILB_SH);
        else if (hil_on)
            sum_v = sum_v - (AW+2)'(fir_acc >>> `HSM_HILB_SH);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dac_out <= '0;
        else
            dac_out <= sat(sum_v);
    end

endmodule : hsm_top
`default_nettype wire

// ---- tb/hsm_sync_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsm_sync_peer
(
    // Control.
    input wire logic en,
    // Reference pin.
    output logic ref_o,
    output logic ref_oe
);
    assign ref_oe = en;
    initial
    begin
        ref_o = 1'b0;
        #13;
        forever
        begin
            #80;
            ref_o = ~ref_o;
        end
    end
endmodule : hsm_sync_peer
`default_nettype wire

// ---- tb/hsm_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsm_top_checker
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register bus.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Reference pin.
    input wire logic sync_reference_clock_pin_o,
    input wire logic sync_reference_clock_pin_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    chk_wait_one: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait while idle");
    chk_unmap_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'hc
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    chk_status_pad: assert property (avs_read && !avs_waitrequest && avs_address == 4'h8
        |-> avs_readdata[31:10] == 22'h0) else $error("status pad");
    chk_phase_pad: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
        |-> avs_readdata[31:8] == 24'h0) else $error("phase pad");
    chk_ctrl_pad: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
        |-> avs_readdata[31:11] == 21'h0) else $error("ctrl pad");
    chk_mst_high: assert property (disable iff (!nrst || !sync_reference_clock_pin_oe)
        $rose(sync_reference_clock_pin_o) && $past(sync_reference_clock_pin_oe)
        |=> sync_reference_clock_pin_o [*7] ##1 !sync_reference_clock_pin_o)
        else $error("reference high phase");
    chk_mst_low: assert property (disable iff (!nrst || !sync_reference_clock_pin_oe)
        $fell(sync_reference_clock_pin_o) && $past(sync_reference_clock_pin_oe)
        |=> !sync_reference_clock_pin_o [*7] ##1 sync_reference_clock_pin_o)
        else $error("reference low phase");
endmodule : hsm_top_checker
bind hsm_top hsm_top_checker hsm_top_checker_i (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sync_reference_clock_pin_o(sync_reference_clock_pin_o),
    .sync_reference_clock_pin_oe(sync_reference_clock_pin_oe));
`default_nettype wire

// ---- tb/test_hilbert_sideband_modulator_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_hilbert_sideband_modulator_sync;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, latch, pin_o, pin_oe;
    logic peer_en, peer_o, peer_oe;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic signed [15:0] i_in, q_in, dac_out;
    logic [31:0] cfg [5] = '{32'h0, 32'hc, 32'h2, 32'h1, 32'h7};
    logic [31:0] ex [5] = '{32'h4d2, 32'h4d2, 32'hfcf7, 32'h4d2, 32'hfcf7};
    wire logic pin;
    int n_fail = 0, checks_done = 0, cyc = 0, n, m;
    assign pin = pin_oe ? pin_o : (peer_oe ? peer_o : 1'b0);
    hsm_top hsm_top_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .i_in(i_in), .q_in(q_in),
        .dac_out(dac_out), .data_latch_clk(latch), .sync_reference_clock_pin_i(pin),
        .sync_reference_clock_pin_o(pin_o), .sync_reference_clock_pin_oe(pin_oe));
    hsm_sync_peer hsm_sync_peer_i (.en(peer_en), .ref_o(peer_o), .ref_oe(peer_oe));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
        acc(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rd
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end
    initial
    begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        i_in = 16'sd0;
        q_in = 16'sd0;
        peer_en = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h0, "ctrl reset");
        rd(4'h4, 32'h0, "phase reset");
        acc(1'b1, 4'hc, 32'hff);
        rd(4'hc, 32'h0, "unmapped");
        acc(1'b1, 4'h0, 32'h7bf);
        rd(4'h0, 32'h7bf, "ctrl");
        $display("test registers done");
        acc(1'b1, 4'h0, 32'h30);
        repeat (40) @(posedge clk);
        chk("master oe", 32'h1, {31'h0, pin_oe});
        n = 0;
        while (pin_o !== 1'b1) @(negedge clk);
        while (pin_o !== 1'b0) @(negedge clk);
        while (pin_o !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        chk("low run", 32'd8, 32'(n));
        $display("test master done");
        acc(1'b1, 4'h0, 32'h10);
        peer_en <= 1'b1;
        repeat (200) @(posedge clk);
        chk("slave oe", 32'h0, {31'h0, pin_oe});
        acc(1'b0, 4'h8, 32'h0);
        chk("locked", 32'h1, {31'h0, q[9]});
        @(posedge peer_o);
        acc(1'b0, 4'h8, 32'h0);
        chk("slave state", 32'h1, {28'h0, q[3:0]});
        acc(1'b1, 4'h4, 32'h85);
        rd(4'h4, 32'h85, "offsets");
        repeat (40) @(posedge clk);
        acc(1'b0, 4'h8, 32'h0);
        chk("phase used", 32'h5, {28'h0, q[8:5]});
        $display("test slave done");
        peer_en <= 1'b0;
        i_in <= 16'sd1234;
        q_in <= -16'sd777;
        for (int k = 0; k < 5; k++)
        begin
            acc(1'b1, 4'h0, cfg[k]);
            repeat (60) @(posedge clk);
            chk("dac", ex[k], {16'h0, dac_out});
        end
        $display("test routing done");
        n = 0;
        repeat (32)
        begin
            @(negedge clk);
            n += int'(latch);
        end
        chk("latch duty", 32'd16, 32'(n));
        acc(1'b1, 4'h0, 32'h5);
        repeat (60) @(posedge clk);
        q_in <= 16'sd0;
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            if (int'(dac_out) > n)
                n = int'(dac_out);
        end
        chk("upper reject peak", 32'd1950, 32'(n));
        acc(1'b1, 4'h0, 32'hd);
        q_in <= -16'sd777;
        repeat (60) @(posedge clk);
        q_in <= 16'sd0;
        m = 32767;
        repeat (40)
        begin
            @(negedge clk);
            if (int'(dac_out) < m)
                m = int'(dac_out);
        end
        chk("lower reject dip", 32'd518, 32'(m));
        $display("test hilbert done");
        acc(1'b1, 4'h0, 32'h80);
        repeat (60) @(posedge clk);
        n = -32768;
        m = 32767;
        repeat (16)
        begin
            @(negedge clk);
            if (int'(dac_out) > n)
                n = int'(dac_out);
            if (int'(dac_out) < m)
                m = int'(dac_out);
        end
        chk("fs2 peak", 32'd1234, 32'(n));
        chk("fs2 dip", 32'hfffffb2e, 32'(m));
        $display("test modulation done");
        finish_test();
    end
endmodule : test_hilbert_sideband_modulator_sync
`default_nettype wire
